// [rtl/gdb_brake_seq.sv]
`timescale 1ns/100ps
module gdb_brake_seq import gdb_pkg::*; (
   input  wire logic              pclk,     // system clock
   input  wire logic              presetn,  // async reset, low
   input  wire logic              start,    // brake request level
   input  wire logic [3*CCP_W-1:0] ccp,     // per-bridge intervals
   input  wire logic [NB-1:0]     active,   // bridges in mode 01/10
   output gdb_seq_e               state,    // sequencer step
   output logic      [NB-1:0]     disch,    // active turn-off per bridge
   output logic                   pump_off, // pump forced off
   output logic                   brake_on  // final brake step
);

   gdb_seq_e             next_state;
   logic [CCP_W-1:0]     cnt;
   logic [NB-1:0]        act_l;
   logic [CCP_W-1:0]     max_ccp;

   // longest interval among latched bridges
   always_comb begin
      max_ccp = '0;
      for (int i = 0; i < NB; i++) begin
         if (act_l[i] && ccp[i*CCP_W +: CCP_W] > max_ccp) begin
            max_ccp = ccp[i*CCP_W +: CCP_W];
         end
      end
   end

   // step order: turn-off, pump off, brake; drop ends it
   always_comb begin
      case (state)
         SEQ_IDLE:    next_state = start ? SEQ_DISCH : SEQ_IDLE;
         SEQ_DISCH:   next_state = !start ? SEQ_IDLE :
                         (cnt >= max_ccp ? SEQ_PUMPOFF : SEQ_DISCH);
         SEQ_PUMPOFF: next_state = start ? SEQ_BRAKE : SEQ_IDLE;
         SEQ_BRAKE:   next_state = start ? SEQ_BRAKE : SEQ_IDLE;
         default:     next_state = SEQ_IDLE;
      endcase
   end

   // state, interval counter and latched bridge set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SEQ_IDLE;
         cnt   <= '0;
         act_l <= '0;
      end else begin
         state <= next_state;
         cnt   <= (state == SEQ_DISCH) ? cnt + 1'b1 : '0;
         if (state == SEQ_IDLE) begin
            act_l <= active;
         end
      end
   end

   // each latched bridge discharges for its own interval
   always_comb begin
      for (int i = 0; i < NB; i++) begin
         disch[i] = (state == SEQ_DISCH) && act_l[i] &&
                    (cnt < ccp[i*CCP_W +: CCP_W]);
      end
   end

   assign pump_off = (state == SEQ_PUMPOFF) || (state == SEQ_BRAKE);
   assign brake_on = (state == SEQ_BRAKE);

endmodule // gdb_brake_seq

// [rtl/gdb_ctrl.sv]
// How it works
// - regulator undervoltage, or in run: mode 00, pump off, overcurrent
// - supply overvoltage, pump undervoltage/blanking, pump overheat force off
// - in run, gates stay pulled down after drain-source overvoltage handling
// - non-run modes keep pull-downs; low-sides freed in parking/ov braking
// - slam brake only runs while in the run mode
// - slam first actively turns off 01/10 bridges for their interval
// - after turn-off step, pump switches off whatever enable says
// - slam final step: first pwm pin drives the non-excluded low-sides directly
// - per low-side bit excludes it from slam switching
// - parking on stop/sleep: turn off, pump off, free low pull-downs
// - parking last step: pwm pin high turns low-sides on
// - gate level bit selects 11 V or 15 V pump target
// - stage-auto 0 keeps dual stage; 1 switches with supply hysteresis
// - modulation bit enables 15.6 kHz pump clock modulation
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module gdb_ctrl import gdb_pkg::*; (
   input  wire logic              pclk,        // system clock
   input  wire logic              presetn,     // async reset, low
   input  wire logic              psel,        // apb select
   input  wire logic              penable,     // apb access phase
   input  wire logic              pwrite,      // apb direction
   input  wire logic [7:0]        paddr,       // apb byte address
   input  wire logic [31:0]       pwdata,      // apb write data
   output logic      [31:0]       prdata,      // apb read data
   output logic                   pready,      // apb ready
   output logic                   pslverr,     // apb error
   input  wire gdb_opmode_e       op_mode,     // device operating mode
   input  wire logic              ov_brake,    // overvoltage braking active
   input  wire gdb_fault_s        fault_pin,   // analog fault levels
   input  wire logic              first_pwm_input_pin, // brake pwm pin
   input  wire logic [NPWM-1:0]   pwm_pin,     // pwm input pins
   output gdb_drive_s             drive,       // gate driver controls
   output gdb_pump_s              pump         // charge pump controls
);

   // software registers
   logic [31:0]          bridge_cfg;
   logic [31:0]          gen_ctrl;
   logic [31:0]          brake_reg;
   logic [31:0]          ccp_reg;

   // pin synchronisers
   localparam int SW = $bits(gdb_fault_s) + NPWM + 1;
   logic [SW-1:0]        sync_a;
   logic [SW-1:0]        sync_b;
   gdb_fault_s           flt;
   logic [NPWM-1:0]      pwm_s;
   logic                 pwm1_s;

   // decoded fields
   logic [1:0]           bridge_mode_code [NB];
   logic [NB-1:0]        bridge_pwm_enable;
   logic [2:0]           pwm_channel_select;
   logic                 charge_pump_enable;
   logic                 overcurrent_shutdown_enable;
   logic                 parking_brake_enable;
   logic                 gate_level_select;
   logic                 pump_stage_auto_select;
   logic                 pump_freq_modulation;
   logic                 slam_req;
   logic [NB-1:0]        slam_exclude;

   // state and control wires
   wire                  run = (op_mode == OP_RUN);
   wire                  lowpwr = (op_mode == OP_STOP) ||
                                  (op_mode == OP_SLEEP);
   wire                  slam_start;
   wire                  park_start;
   wire                  pwm_chosen;
   wire                  global_pd;
   wire                  run_all_pd;
   logic [NB-1:0]        active;
   gdb_seq_e             seq_state;
   logic [NB-1:0]        seq_disch;
   logic                 seq_pump_off;
   logic                 seq_brake;
   logic                 slam_kind;
   gdb_drive_s           next_drive;
   logic                 single_stage;
   logic [15:0]          fm_cnt;
   logic                 fm_clk;

   // apb decode
   wire                  setup = psel && !penable;
   wire                  acc   = psel && penable;
   wire                  hit_bc  = (paddr == BRIDGE_CFG_OFS);
   wire                  hit_gc  = (paddr == GEN_CTRL_OFS);
   wire                  hit_br  = (paddr == BRAKE_OFS);
   wire                  hit_ccp = (paddr == CCP_OFS);
   wire                  hit_st  = (paddr == STATUS_OFS);
   wire                  mapped  = hit_bc | hit_gc | hit_br |
                                   hit_ccp | hit_st;
   wire                  wr = acc && pwrite;
   logic [31:0]          status_word;
   logic [31:0]          next_rdata;

   // zero-wait slave, error on unmapped address
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_cfg <= BRIDGE_CFG_RST;
         gen_ctrl   <= GEN_CTRL_RST;
         brake_reg  <= BRAKE_RST;
         ccp_reg    <= CCP_RST;
      end else begin
         if (wr && hit_bc)  bridge_cfg <= pwdata & 32'h0000_0FFF;
         if (wr && hit_gc)  gen_ctrl   <= pwdata & 32'h0000_003F;
         if (wr && hit_br)  brake_reg  <= pwdata & 32'h0000_000F;
         if (wr && hit_ccp) ccp_reg    <= pwdata & 32'h00FF_FFFF;
      end
   end

   // field decoding
   always_comb begin
      for (int i = 0; i < NB; i++) begin
         bridge_mode_code[i] = bridge_cfg[BC_MODE_LSB + 2*i +: 2];
      end
   end
   assign bridge_pwm_enable  = bridge_cfg[BC_PWMEN_LSB +: NB];
   assign pwm_channel_select = bridge_cfg[BC_CHSEL_LSB +: 3];
   assign charge_pump_enable          = gen_ctrl[GC_CHARGE_PUMP_ENABLE];
   assign overcurrent_shutdown_enable = gen_ctrl[GC_OVERCURRENT_SHUTDOWN_ENABLE];
   assign parking_brake_enable        = gen_ctrl[GC_PARK];
   assign gate_level_select           = gen_ctrl[GC_LVL];
   assign pump_stage_auto_select      = gen_ctrl[GC_STGA];
   assign pump_freq_modulation        = gen_ctrl[GC_FMOD];
   assign slam_req     = brake_reg[BR_SLAM];
   assign slam_exclude = brake_reg[BR_EXCL_LSB +: NB];

   // status word shows sequencer, pump and gate state
   assign status_word = {15'h0000, drive, seq_state[1:0]} ^
                        {12'h000, single_stage, seq_pump_off,
                         18'h00000};

   // read data captured in setup phase
   always_comb begin
      case (1'b1)
         hit_bc:  next_rdata = bridge_cfg;
         hit_gc:  next_rdata = gen_ctrl;
         hit_br:  next_rdata = brake_reg;
         hit_ccp: next_rdata = ccp_reg;
         hit_st:  next_rdata = status_word;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
   end

   // two-flop synchronisers for pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {fault_pin, pwm_pin, first_pwm_input_pin};
         sync_b <= sync_a;
      end
   end
   assign flt    = sync_b[SW-1 -: $bits(gdb_fault_s)];
   assign pwm_s  = sync_b[NPWM:1];
   assign pwm1_s = sync_b[0];

   // selected pwm source for normal drive
   assign pwm_chosen = (pwm_channel_select < 3'(NPWM)) ?
                       pwm_s[pwm_channel_select] : pwm_s[0];

   // brake requests
   assign slam_start = run && slam_req;
   assign park_start = parking_brake_enable && lowpwr;

   always_comb begin
      for (int i = 0; i < NB; i++) begin
         active[i] = is_active_mode(bridge_mode_code[i]);
      end
   end

   // remember which brake is running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slam_kind <= 1'b0;
      end else if (seq_state == SEQ_IDLE) begin
         slam_kind <= slam_start;
      end
   end

   gdb_brake_seq u_seq (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (slam_start || park_start),
      .ccp      (ccp_reg[3*CCP_W-1:0]),
      .active   (active),
      .state    (seq_state),
      .disch    (seq_disch),
      .pump_off (seq_pump_off),
      .brake_on (seq_brake)
   );

   // pull-down causes shared by all bridges
   assign global_pd = flt.main_reg_uv |
                      flt.vs_ov | flt.internal_supply_input_ov |
                      flt.cp_uv | flt.cp_blank | flt.pump_overtemperature;
   assign run_all_pd = run && (!charge_pump_enable ||
                       (overcurrent_shutdown_enable && flt.oc_det));

   // gate decisions per bridge
   always_comb begin
      logic mode_pd;
      logic ls_free;
      logic hs_want;
      logic ls_want;
      mode_pd = 1'b0;
      ls_free = 1'b0;
      hs_want = 1'b0;
      ls_want = 1'b0;
      next_drive = '0;
      for (int i = 0; i < NB; i++) begin
         mode_pd = run ? (run_all_pd ||
                          bridge_mode_code[i] == MODE_OFF ||
                          flt.vds_ov_done[i])
                       : 1'b1;
         // low-sides freed while a brake owns them
         ls_free = seq_brake || (!run && ov_brake);
         hs_want = 1'b0;
         ls_want = 1'b0;
         if (seq_brake) begin
            ls_want = slam_kind ?
                      (pwm1_s && !slam_exclude[i]) :
                      pwm1_s;
         end else if (seq_state == SEQ_IDLE && run) begin
            // normal drive once slam is gone
            if (bridge_mode_code[i] == MODE_HS) begin
               hs_want = bridge_pwm_enable[i] ? pwm_chosen : 1'b1;
            end
            if (bridge_mode_code[i] == MODE_LS) begin
               ls_want = bridge_pwm_enable[i] ? pwm_chosen : 1'b1;
            end
         end
         next_drive.disch[i] = seq_disch[i];
         next_drive.hs_pd[i] = global_pd || mode_pd ||
                               (seq_state != SEQ_IDLE);
         next_drive.ls_pd[i] = global_pd ||
                               (mode_pd && !ls_free);
         next_drive.hs_on[i] = hs_want && !next_drive.hs_pd[i];
         next_drive.ls_on[i] = ls_want && !next_drive.ls_pd[i];
      end
   end

   // gate controls registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '{default: '0};
      end else begin
         drive <= next_drive;
      end
   end

   // stage selection with supply hysteresis
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_stage <= 1'b0;
      end else if (!pump_stage_auto_select) begin
         single_stage <= 1'b0;
      end else if (flt.vs_above_upper) begin
         single_stage <= 1'b1;
      end else if (flt.vs_below_lower) begin
         single_stage <= 1'b0;
      end
   end

   // modulation clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fm_cnt <= '0;
         fm_clk <= 1'b0;
      end else if (!pump_freq_modulation) begin
         fm_cnt <= '0;
         fm_clk <= 1'b0;
      end else if (fm_cnt == 16'(FM_HALF_CYC - 1)) begin
         fm_cnt <= '0;
         fm_clk <= ~fm_clk;
      end else begin
         fm_cnt <= fm_cnt + 16'h0001;
      end
   end

   // pump outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump <= '{default: '0};
      end else begin
         pump.enable <= charge_pump_enable && !seq_pump_off;
         pump.single_stage <= single_stage;
         pump.fm_clk <= fm_clk;
         pump.target_v <= gate_level_select ? GATE_NORMAL_V
                                            : GATE_LOGIC_V;
      end
   end

endmodule // gdb_ctrl

// [rtl/gdb_pkg.sv]
package gdb_pkg;

   // bridge count and register widths
   localparam int NB        = 3;
   localparam int CCP_W     = 8;
   localparam int NPWM      = 6;

   // register byte offsets
   localparam logic [7:0] BRIDGE_CFG_OFS = 8'h00;
   localparam logic [7:0] GEN_CTRL_OFS   = 8'h04;
   localparam logic [7:0] BRAKE_OFS      = 8'h08;
   localparam logic [7:0] CCP_OFS        = 8'h0C;
   localparam logic [7:0] STATUS_OFS     = 8'h10;

   // bridge config fields
   localparam int BC_MODE_LSB  = 0;
   localparam int BC_PWMEN_LSB = 6;
   localparam int BC_CHSEL_LSB = 9;

   // general control fields
   localparam int GC_CHARGE_PUMP_ENABLE = 0;
   localparam int GC_OVERCURRENT_SHUTDOWN_ENABLE = 1;
   localparam int GC_PARK = 2;
   localparam int GC_LVL  = 3;
   localparam int GC_STGA = 4;
   localparam int GC_FMOD = 5;

   // brake register fields
   localparam int BR_SLAM     = 0;
   localparam int BR_EXCL_LSB = 1;

   // reset values
   localparam logic [31:0] BRIDGE_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] GEN_CTRL_RST   = 32'h0000_0021;
   localparam logic [31:0] BRAKE_RST      = 32'h0000_0000;
   localparam logic [31:0] CCP_RST        = 32'h0010_1010;

   // clock, and pump modulation frequency in 100 Hz steps
   localparam int CLK_HZ      = 25_000_000;
   localparam int FM_FREQ_DHZ = 156;
   localparam int FM_HALF_CYC = (CLK_HZ / 100) / (2 * FM_FREQ_DHZ);

   // pump regulation targets above the motor supply, volts
   localparam logic [4:0] GATE_LOGIC_V  = 5'h0B;
   localparam logic [4:0] GATE_NORMAL_V = 5'h0F;

   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_LS  = 2'b01,
      MODE_HS  = 2'b10,
      MODE_RSV = 2'b11
   } gdb_hbmode_e;

   typedef enum logic [2:0] {
      OP_INIT     = 3'b000,
      OP_RUN      = 3'b001,
      OP_STOP     = 3'b010,
      OP_FAILSAFE = 3'b011,
      OP_RESTART  = 3'b100,
      OP_SLEEP    = 3'b101
   } gdb_opmode_e;

   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_DISCH   = 2'b01,
      SEQ_PUMPOFF = 2'b10,
      SEQ_BRAKE   = 2'b11
   } gdb_seq_e;

   typedef struct packed {
      logic          main_reg_uv;
      logic          vs_ov;
      logic          internal_supply_input_ov;
      logic          cp_uv;
      logic          cp_blank;
      logic          pump_overtemperature;
      logic          oc_det;
      logic [NB-1:0] vds_ov_done;
      logic          vs_above_upper;
      logic          vs_below_lower;
   } gdb_fault_s;

   typedef struct packed {
      logic [NB-1:0] hs_on;
      logic [NB-1:0] ls_on;
      logic [NB-1:0] hs_pd;
      logic [NB-1:0] ls_pd;
      logic [NB-1:0] disch;
   } gdb_drive_s;

   typedef struct packed {
      logic       enable;
      logic       single_stage;
      logic       fm_clk;
      logic [4:0] target_v;
   } gdb_pump_s;

   // bridge takes part in active turn-off
   function automatic logic is_active_mode(input logic [1:0] m);
      return (m == MODE_LS) || (m == MODE_HS);
   endfunction

endpackage

// [test/gdb_ctrl_props.sv]
`timescale 1ns/100ps
module gdb_ctrl_props import gdb_pkg::*; (
   input wire logic        pclk,      // clock
   input wire logic        presetn,   // async reset, low
   input wire logic        psel,      // apb select
   input wire logic        penable,   // apb access
   input wire logic [7:0]  paddr,     // apb address
   input wire logic        pready,    // apb ready
   input wire logic        pslverr,   // apb error
   input wire gdb_opmode_e op_mode,   // operating mode
   input wire gdb_fault_s  fault_pin, // fault levels
   input wire gdb_drive_s  drive,     // gate controls
   input wire gdb_pump_s   pump       // pump controls
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   int   fm_cnt;
   logic fell_seen;

   // cycles since the modulation clock last changed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fm_cnt    <= 0;
         fell_seen <= 1'b0;
      end else if ($changed(pump.fm_clk)) begin
         fm_cnt <= 0;
         if ($fell(pump.fm_clk)) fell_seen <= 1'b1;
      end else begin
         fm_cnt <= fm_cnt + 1;
      end
   end

   a_uv_pulldown: assert property (fault_pin.main_reg_uv [*3] |=>
      &drive.hs_pd && &drive.ls_pd) else $error("uv left gates free");
   a_supply_fault_pd: assert property ((fault_pin.vs_ov ||
      fault_pin.internal_supply_input_ov || fault_pin.cp_uv || fault_pin.cp_blank ||
      fault_pin.pump_overtemperature) [*3] |=> &drive.hs_pd && &drive.ls_pd)
      else $error("supply fault left gates free");
   a_nonrun_hs_pd: assert property ((op_mode != OP_RUN) [*2] |=>
      &drive.hs_pd) else $error("high side free outside run");
   a_slam_run_only: assert property ((op_mode inside
      {OP_INIT, OP_FAILSAFE, OP_RESTART}) [*3] |=> drive.disch == '0)
      else $error("discharge outside run");
   a_brake_pump_off: assert property ($past(op_mode) != OP_RUN &&
      op_mode != OP_RUN && |drive.ls_on |-> !pump.enable)
      else $error("pump on while braking");
   a_fm_half_period: assert property ($rose(pump.fm_clk) &&
      fell_seen |-> fm_cnt == FM_HALF_CYC - 1)
      else $error("modulation period wrong");
   a_pump_target: assert property ($past(presetn) |->
      pump.target_v inside {5'h0B, 5'h0F}) else $error("bad pump target");
   a_stage_drop: assert property ((fault_pin.vs_below_lower &&
      !fault_pin.vs_above_upper) [*4] |=> !pump.single_stage)
      else $error("single stage below threshold");
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("apb not ready");
   a_apb_unmapped: assert property (psel && penable && paddr > 8'h10
      |-> pslverr) else $error("unmapped access not refused");

   c_slam: cover property (op_mode == OP_RUN && !pump.enable &&
      |drive.ls_on);
   c_disch: cover property (|drive.disch);
   c_fm: cover property ($rose(pump.fm_clk) && fell_seen);
endmodule // gdb_ctrl_props

bind gdb_ctrl gdb_ctrl_props i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .op_mode(op_mode), .fault_pin(fault_pin),
   .drive(drive), .pump(pump));

// [test/gdb_fet_model.sv]
`timescale 1ns/100ps
module gdb_fet_model import gdb_pkg::*; (
   input  wire gdb_drive_s    drive,   // gate driver controls
   output logic [NB-1:0]      hs_gate, // high-side gate charged
   output logic [NB-1:0]      ls_gate, // low-side gate charged
   output logic               shoot    // a leg conducts top and bottom
);
   // a gate holds charge only when driven and neither pulled nor discharged
   assign hs_gate = drive.hs_on & ~drive.hs_pd & ~drive.disch;
   assign ls_gate = drive.ls_on & ~drive.ls_pd & ~drive.disch;
   assign shoot   = |(hs_gate & ls_gate);
endmodule // gdb_fet_model

// [test/test_gdb_ctrl.sv]
`timescale 1ns/100ps
module test_gdb_ctrl import gdb_pkg::*; ;
   logic            pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic            pwrite = 0, ov_brake = 0, pwm1 = 0, fmp;
   logic            pready, pslverr, err, shoot;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0, prdata, rd;
   logic [NPWM-1:0] pwm_pin = 6'h00;
   logic [NB-1:0]   hs_gate, ls_gate;
   gdb_opmode_e     op_mode = OP_INIT;
   gdb_fault_s      fault_pin = '0;
   gdb_drive_s      drive;
   gdb_pump_s       pump;
   int              num_errors = 0, checks_done = 0, cycles = 0;
   int              seed = 32'h8F1D, nchg, exp_brake;
   int              dcnt [NB];
   logic [31:0]     mdl [4] = '{32'h0, 32'h21, 32'h0, 32'h10_1010};
   logic [31:0]     rst_v [4] = '{32'h0, 32'h21, 32'h0, 32'h10_1010};
   logic [31:0]     msk_v [4] = '{32'hFFF, 32'h3F, 32'hF, 32'hFF_FFFF};

   gdb_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_mode(op_mode), .ov_brake(ov_brake), .fault_pin(fault_pin),
      .first_pwm_input_pin(pwm1), .pwm_pin(pwm_pin), .drive(drive),
      .pump(pump));
   gdb_fet_model i_fets (.drive(drive), .hs_gate(hs_gate),
      .ls_gate(ls_gate), .shoot(shoot));

   // clock, hang limit and discharge cycle counting
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         close_out();
      end
      for (int i = 0; i < NB; i++) if (drive.disch[i] === 1'b1) dcnt[i]++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; the model registers follow accepted writes
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (wr && err === 1'b0 && a < STATUS_OFS) mdl[a>>2] = d & msk_v[a>>2];
   endtask

   task automatic cmp_reg(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_bit(input string n, input logic e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic cmp_drv(input gdb_drive_s e, g, input logic pd_only);
      logic [14:0] m;
      m = pd_only ? 15'h01F8 : 15'h7FFF;
      checks_done++;
      if ((g & m) !== (e & m)) begin
         num_errors++;
         $display("mismatch drive expected %h seen %h", e & m, g & m);
      end
   endtask

   // expected gate controls once the inputs have settled
   function automatic gdb_drive_s exp_drv();
      gdb_drive_s d;
      int m, p, sel, run, slam, glob, all_pd;
      d = '0;
      run = (op_mode == OP_RUN);
      slam = run && mdl[2][BR_SLAM];
      exp_brake = slam || (mdl[1][GC_PARK] &&
                  (op_mode == OP_STOP || op_mode == OP_SLEEP));
      glob = |{fault_pin.main_reg_uv, fault_pin.vs_ov, fault_pin.internal_supply_input_ov,
               fault_pin.cp_uv, fault_pin.cp_blank, fault_pin.pump_overtemperature};
      all_pd = glob || !run || !mdl[1][GC_CHARGE_PUMP_ENABLE] ||
               (mdl[1][GC_OVERCURRENT_SHUTDOWN_ENABLE] && fault_pin.oc_det);
      sel = mdl[0][BC_CHSEL_LSB+:3];
      for (int i = 0; i < NB; i++) begin
         m = mdl[0][2*i+:2];
         p = mdl[0][BC_PWMEN_LSB+i] ? pwm_pin[sel >= 6 ? 0 : sel] : 1;
         if (exp_brake) begin
            d.hs_pd[i] = 1'b1;
            d.ls_pd[i] = glob;
            d.ls_on[i] = pwm1 && !(slam && mdl[2][BR_EXCL_LSB+i]);
         end else begin
            d.hs_pd[i] = all_pd || m == 0 || fault_pin.vds_ov_done[i];
            d.ls_pd[i] = d.hs_pd[i] && !(!run && ov_brake && !glob);
            d.hs_on[i] = !d.hs_pd[i] && m == 2 && p;
            d.ls_on[i] = !d.hs_pd[i] && m == 1 && p;
         end
      end
      return d;
   endfunction

   task automatic chk(input logic pd_only);
      cyc(6);
      cmp_drv(exp_drv(), drive, pd_only);
      cmp_bit("pump enable", mdl[1][GC_CHARGE_PUMP_ENABLE] && !exp_brake, pump.enable);
      cmp_bit("shoot through", 1'b0, shoot);
   endtask

   task automatic close_out();
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // main sequence
   initial begin
      cyc(3);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4*i), 32'h0);
         cmp_reg("reset value", rst_v[i], rd);
      end
      cyc(1700);
      nchg = 0;
      fmp = pump.fm_clk;
      repeat (3204) begin
         @(posedge pclk);
         if (pump.fm_clk !== fmp) nchg++;
         fmp = pump.fm_clk;
      end
      cmp_reg("fm changes", 32'h4, nchg);
      apb(1'b1, GEN_CTRL_OFS, 32'h01);
      cyc(900);
      cmp_bit("fm clock", 1'b0, pump.fm_clk);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'(4*i), $random(seed) & (i == 1 ? 32'h1F : 32'hFFFF_FFFF));
         apb(1'b0, 8'(4*i), 32'h0);
         cmp_reg("readback", mdl[i], rd);
      end
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      cmp_bit("pslverr", 1'b1, err);
      apb(1'b0, 8'h14, 32'h0);
      cmp_reg("unmapped read", 32'h0, rd);
      apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
      cmp_bit("pslverr", 1'b0, err);
      apb(1'b1, BRIDGE_CFG_OFS, 32'h7C9);
      apb(1'b1, CCP_OFS, 32'h02_0604);
      apb(1'b1, GEN_CTRL_OFS, 32'h03);
      apb(1'b1, BRAKE_OFS, 32'h0);
      for (int k = 0; k < 6; k++) begin
         op_mode <= gdb_opmode_e'(k);
         ov_brake <= 1'b0;
         chk(1'b0);
         ov_brake <= 1'b1;
         chk(1'b1);
      end
      op_mode <= OP_RUN;
      ov_brake <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         pwm_pin <= 6'($random(seed));
         apb(1'b1, BRIDGE_CFG_OFS, $random(seed));
         chk(1'b0);
      end
      apb(1'b1, BRIDGE_CFG_OFS, 32'h7C9);
      for (int k = 2; k < 12; k++) begin
         fault_pin <= 12'h001 << k;
         chk(1'b1);
      end
      fault_pin <= '0;
      apb(1'b1, GEN_CTRL_OFS, 32'h00);
      chk(1'b1);
      apb(1'b1, GEN_CTRL_OFS, 32'h01);
      for (int k = 0; k < 2; k++) begin
         dcnt = '{0, 0, 0};
         pwm1 <= 1'b1;
         if (k == 0) apb(1'b1, BRAKE_OFS, 32'h5);
         else begin
            apb(1'b1, BRAKE_OFS, 32'h4);
            apb(1'b1, GEN_CTRL_OFS, 32'h05);
            op_mode <= OP_SLEEP;
         end
         cyc(30);
         for (int i = 0; i < NB; i++)
            cmp_reg("disch cycles", i == 2 ? 0 : mdl[3][8*i+:8],
                    dcnt[i]);
         chk(1'b0);
         pwm1 <= 1'b0;
         chk(1'b0);
         apb(1'b1, BRAKE_OFS, 32'h0);
         op_mode <= OP_RUN;
         chk(1'b0);
      end
      apb(1'b1, GEN_CTRL_OFS, 32'h01);
      op_mode <= OP_STOP;
      dcnt = '{0, 0, 0};
      pwm1 <= 1'b1;
      apb(1'b1, BRAKE_OFS, 32'h1);
      cyc(30);
      cmp_reg("disch cycles", 32'h0, dcnt[0] + dcnt[1] + dcnt[2]);
      chk(1'b0);
      fault_pin <= 12'h002;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, GEN_CTRL_OFS, 32'h01 | (k << 3));
         cyc(6);
         cmp_reg("pump target", k[0] ? 32'hF : 32'hB,
                 32'(pump.target_v));
         cmp_bit("single stage", k[1], pump.single_stage);
      end
      fault_pin <= 12'h001;
      cyc(6);
      cmp_bit("single stage", 1'b0, pump.single_stage);
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp_reg("status", {15'h0, exp_drv(), 2'b00}, rd);
      close_out();
   end
endmodule // test_gdb_ctrl
